// >>> design/ptw_defines.vh
`ifndef PTW_DEFINES_VH
`define PTW_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PTW_OFF_CTRL    8'h00
`define PTW_OFF_BASE0   8'h04
`define PTW_OFF_BASE1   8'h08
`define PTW_OFF_FSTAT   8'h0C
`define PTW_OFF_FADDR   8'h10
`define PTW_OFF_TLBIDX  8'h14
`define PTW_OFF_TLBLO   8'h18
`define PTW_OFF_TLBHI   8'h1C
`define PTW_OFF_STATUS  8'h20

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define PTW_CTRL_TS     0
`define PTW_CTRL_TU     1
`define PTW_CTRL_DS     2
`define PTW_CTRL_AO     3
`define PTW_CTRL_RST    4'h0
`define PTW_BASE_RST    32'h00000000

// ---------------------------------------------------------------
// page-table entry fields
// ---------------------------------------------------------------
`define PTW_PTE_V       0
`define PTW_PTE_PL_LO   1
`define PTW_PTE_PL_HI   2
`define PTW_PTE_CI      5
`define PTW_PTE_R       7
`define PTW_PTE_M       8
`define PTW_PTE_PFN_LO  12

// ---------------------------------------------------------------
// fault codes
// ---------------------------------------------------------------
`define PTW_FC_NONE     2'h0
`define PTW_FC_L1_INV   2'h1
`define PTW_FC_L2_INV   2'h2
`define PTW_FC_PROT     2'h3

`endif

// >>> design/ptw_tlb_mem.v
`timescale 1ns/1ps
// ---------------------------------------------------------------
// translation-buffer storage, registered read
// ---------------------------------------------------------------
module ptw_tlb_mem #(
  parameter WIDTH = 45,
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire             clk_sys,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// >>> design/ptw_walker.v
`timescale 1ns/1ps
`include "ptw_defines.vh"
// Operation
// - translation off for the mode: physical equals virtual, noncacheable low
// - address space is user AND dual space; space 1 uses second base
// - user-level when user mode, user-to-supervisor source, supervisor-to-user dest
// - access level: upper user AND NOT override, lower write or rmw
// - first entry at base plus va[31:22] times four
// - second entry at first frame, va[21:12], two zero bits
// - physical address is second frame with va[11:0]
// - entry level below access level: record address, code 11, stop
// - first entry invalid: record address, code 01, stop
// - second entry invalid: record address, code 10, stop
// - valid first entry with referenced clear: byte write sets referenced
// - effective level is lower of the two entry levels
// - plain read, second referenced clear: locked rmw sets referenced
// - write or locked read, referenced or modified clear: rmw sets both
// - noncacheable from cache-inhibit bit; low on walker's own cycles
// - success fills a buffer victim with index, space, frame, level, ci, m
// - user 00/01 none, 10 read, 11 full; supervisor 00 read, else full
// - valid bit and level field are never written by hardware
// - spare bits are ignored and written back unchanged
// - modified position of first-level entries is left unaltered
// - fault address and status change only when an abort is taken
// - probe aborts only on invalid first entry whose level permits
module ptw_walker #(
  parameter TLB_DEPTH = 64,
  parameter TLB_AW    = 6
) (
  input  wire        clk_sys,
  input  wire        srst,
  // apb slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // translation request on buffer miss
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [31:0] req_vaddr,
  input  wire        req_user_mode,
  input  wire        req_user_to_supervisor_move,
  input  wire        req_supervisor_to_user_move,
  input  wire        req_write,
  input  wire        req_rmw,
  input  wire        req_probe,
  input  wire        req_speculative,
  output reg         rsp_done,
  output reg  [31:0] rsp_paddr,
  output reg         noncacheable_out,
  output reg         rsp_fault,
  output reg         rsp_abort,
  output reg         rsp_probe_ok,
  // page-table memory port
  output wire        mem_req,
  output reg  [31:0] mem_addr,
  output wire        mem_we,
  output wire        mem_byte,
  output wire        mem_lock,
  output reg  [31:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata
);

  localparam TLB_W = 45;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD1  = 3'h1;
  localparam [2:0] ST_WR1  = 3'h2;
  localparam [2:0] ST_RD2  = 3'h3;
  localparam [2:0] ST_RMWR = 3'h4;
  localparam [2:0] ST_RMWW = 3'h5;

  reg  [3:0]        translation_control_reg;
  reg  [31:0]       table_base_space0;
  reg  [31:0]       table_base_space1;
  reg  [1:0]        fault_code;
  reg  [31:0]       fault_address_reg;
  reg  [TLB_AW-1:0] tlb_index;
  reg  [TLB_AW-1:0] victim;
  reg  [2:0]        state;
  reg  [31:0]       va;
  reg  [31:0]       pte;
  reg  [1:0]        acc_lvl;
  reg  [1:0]        eff_pl;
  reg               addr_space;
  reg               is_write;
  reg               is_rmw;
  reg               is_probe;
  reg               is_spec;
  reg  [31:0]       set_bits;
  reg               tlb_we;
  reg  [TLB_W-1:0]  tlb_wdata;
  wire [TLB_W-1:0]  tlb_rdata;

  wire supervisor_translate_on = translation_control_reg[`PTW_CTRL_TS];
  wire user_translate_on       = translation_control_reg[`PTW_CTRL_TU];
  wire dual_space_select       = translation_control_reg[`PTW_CTRL_DS];
  wire access_override         = translation_control_reg[`PTW_CTRL_AO];

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  wire req_user = req_user_mode | req_user_to_supervisor_move |
                  req_supervisor_to_user_move;
  wire req_as   = req_user & dual_space_select;
  wire [1:0] req_lvl = {req_user & ~access_override,
                        req_write | req_rmw};
  wire xlate_off = (~req_user & ~supervisor_translate_on) |
                   (req_user & ~user_translate_on);
  wire [31:0] req_base = req_as ? table_base_space1
                                : table_base_space0;
  wire [31:0] l1_ptr = req_base +
                       {20'h00000, req_vaddr[31:22], 2'b00};

  wire [1:0] rd_pl   = mem_rdata[`PTW_PTE_PL_HI:`PTW_PTE_PL_LO];
  wire       rd_v    = mem_rdata[`PTW_PTE_V];
  wire       rd_r    = mem_rdata[`PTW_PTE_R];
  wire       rd_m    = mem_rdata[`PTW_PTE_M];
  wire [19:0] rd_pfn = mem_rdata[31:`PTW_PTE_PFN_LO];
  wire [1:0] min_pl  = (rd_pl < eff_pl) ? rd_pl : eff_pl;
  wire need_r  = ~is_write & ~is_rmw & ~rd_r;
  wire need_rm = (is_write | is_rmw) & (~rd_r | ~rd_m);

  // permission per level and mode
  function permit;
    input       user;
    input [1:0] pl;
    input       wr;
    begin
      if (user)
        permit = pl[1] & (pl[0] | ~wr);
      else
        permit = (pl != 2'b00) | ~wr;
    end
  endfunction

  // ---------------------------------------------------------------
  // memory port
  // ---------------------------------------------------------------
  assign mem_req  = (state != ST_IDLE);
  assign mem_we   = (state == ST_WR1) | (state == ST_RMWW);
  assign mem_byte = (state == ST_WR1);
  assign mem_lock = (state == ST_RMWR) | (state == ST_RMWW);
  assign req_ready = (state == ST_IDLE);

  // ---------------------------------------------------------------
  // walk sequencer
  // ---------------------------------------------------------------
  task end_fault;
    input [1:0] code;
    reg         trap;
    begin
      trap = ~is_spec & (~is_probe | (code == `PTW_FC_L1_INV));
      rsp_done  <= 1'b1;
      rsp_fault <= 1'b1;
      rsp_abort <= trap;
      if (trap)
      begin
        fault_address_reg <= va;
        fault_code        <= code;
      end
      state <= ST_IDLE;
    end
  endtask

  task end_ok;
    input [31:0] entry;
    input [1:0]  lvl;
    begin
      rsp_done         <= 1'b1;
      rsp_probe_ok     <= is_probe;
      rsp_paddr        <= {entry[31:`PTW_PTE_PFN_LO], va[11:0]};
      noncacheable_out <= entry[`PTW_PTE_CI];
      tlb_we           <= 1'b1;
      tlb_wdata        <= {addr_space, va[31:12],
                           entry[31:`PTW_PTE_PFN_LO], lvl,
                           entry[`PTW_PTE_CI], entry[`PTW_PTE_M]};
      state            <= ST_IDLE;
    end
  endtask

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      state             <= ST_IDLE;
      va                <= 32'h00000000;
      pte               <= 32'h00000000;
      acc_lvl           <= 2'h0;
      eff_pl            <= 2'h0;
      addr_space        <= 1'b0;
      is_write          <= 1'b0;
      is_rmw            <= 1'b0;
      is_probe          <= 1'b0;
      is_spec           <= 1'b0;
      set_bits          <= 32'h00000000;
      mem_addr          <= 32'h00000000;
      mem_wdata         <= 32'h00000000;
      rsp_done          <= 1'b0;
      rsp_paddr         <= 32'h00000000;
      noncacheable_out  <= 1'b0;
      rsp_fault         <= 1'b0;
      rsp_abort         <= 1'b0;
      rsp_probe_ok      <= 1'b0;
      fault_code        <= `PTW_FC_NONE;
      fault_address_reg <= 32'h00000000;
      victim            <= {TLB_AW{1'b0}};
      tlb_we            <= 1'b0;
      tlb_wdata         <= {TLB_W{1'b0}};
    end
    else
    begin
      rsp_done     <= 1'b0;
      rsp_fault    <= 1'b0;
      rsp_abort    <= 1'b0;
      rsp_probe_ok <= 1'b0;
      tlb_we       <= 1'b0;
      // step only after the fill has landed on the old victim
      if (tlb_we)
        victim     <= victim + 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            va         <= req_vaddr;
            acc_lvl    <= req_lvl;
            addr_space <= req_as;
            is_write   <= req_write;
            is_rmw     <= req_rmw;
            is_probe   <= req_probe;
            is_spec    <= req_speculative;
            if (xlate_off)
            begin
              rsp_done         <= 1'b1;
              rsp_probe_ok     <= req_probe &
                                  permit(req_user, 2'b11, req_lvl[0]);
              rsp_paddr        <= req_vaddr;
              noncacheable_out <= 1'b0;
            end
            else
            begin
              noncacheable_out <= 1'b0;
              mem_addr         <= l1_ptr;
              state            <= ST_RD1;
            end
          end
        end
        ST_RD1:
        begin
          if (mem_ack)
          begin
            pte    <= mem_rdata;
            eff_pl <= rd_pl;
            if (rd_pl < acc_lvl)
              end_fault(`PTW_FC_PROT);
            else if (!rd_v)
              end_fault(`PTW_FC_L1_INV);
            else if (!rd_r && !is_probe)
            begin
              // single byte keeps valid, level, spare and m bits
              mem_wdata <= {24'h000000, mem_rdata[7:0]} |
                           (32'h1 << `PTW_PTE_R);
              state     <= ST_WR1;
            end
            else
            begin
              mem_addr <= {rd_pfn, va[21:12], 2'b00};
              state    <= ST_RD2;
            end
          end
        end
        ST_WR1:
        begin
          if (mem_ack)
          begin
            mem_addr <= {pte[31:`PTW_PTE_PFN_LO], va[21:12], 2'b00};
            state    <= ST_RD2;
          end
        end
        ST_RD2:
        begin
          if (mem_ack)
          begin
            pte    <= mem_rdata;
            eff_pl <= min_pl;
            if (rd_pl < acc_lvl)
              end_fault(`PTW_FC_PROT);
            else if (!rd_v)
              end_fault(`PTW_FC_L2_INV);
            else if (!is_probe && (need_r || need_rm))
            begin
              set_bits <= need_rm ? ((32'h1 << `PTW_PTE_R) |
                                     (32'h1 << `PTW_PTE_M))
                                  : (32'h1 << `PTW_PTE_R);
              state    <= ST_RMWR;
            end
            else
              end_ok(mem_rdata, min_pl);
          end
        end
        ST_RMWR:
        begin
          if (mem_ack)
          begin
            // fresh locked copy, only r/m ored in
            mem_wdata <= mem_rdata | set_bits;
            state     <= ST_RMWW;
          end
        end
        ST_RMWW:
        begin
          if (mem_ack)
            end_ok(mem_wdata, eff_pl);
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // translation buffer
  // ---------------------------------------------------------------
  ptw_tlb_mem #(
    .WIDTH   (TLB_W),
    .DEPTH   (TLB_DEPTH),
    .AW      (TLB_AW)
  ) u_tlb (
    .clk_sys (clk_sys),
    .wr_en   (tlb_we),
    .wr_addr (victim),
    .wr_data (tlb_wdata),
    .rd_addr (tlb_index),
    .rd_data (tlb_rdata)
  );

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  wire apb_wr = psel & penable & pwrite;
  wire apb_setup = psel & ~penable;
  reg  mapped;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @*
  begin
    case (paddr)
      `PTW_OFF_CTRL, `PTW_OFF_BASE0, `PTW_OFF_BASE1, `PTW_OFF_FSTAT,
      `PTW_OFF_FADDR, `PTW_OFF_TLBIDX, `PTW_OFF_TLBLO, `PTW_OFF_TLBHI,
      `PTW_OFF_STATUS:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      translation_control_reg <= `PTW_CTRL_RST;
      table_base_space0       <= `PTW_BASE_RST;
      table_base_space1       <= `PTW_BASE_RST;
      tlb_index               <= {TLB_AW{1'b0}};
      prdata                  <= 32'h00000000;
    end
    else
    begin
      if (apb_wr)
      begin
        case (paddr)
          `PTW_OFF_CTRL:   translation_control_reg <= pwdata[3:0];
          `PTW_OFF_BASE0:  table_base_space0 <= {pwdata[31:12], 12'h000};
          `PTW_OFF_BASE1:  table_base_space1 <= {pwdata[31:12], 12'h000};
          `PTW_OFF_TLBIDX: tlb_index <= pwdata[TLB_AW-1:0];
          default:         tlb_index <= tlb_index;
        endcase
      end
      if (apb_setup)
      begin
        case (paddr)
          `PTW_OFF_CTRL:   prdata <= {28'h0000000, translation_control_reg};
          `PTW_OFF_BASE0:  prdata <= table_base_space0;
          `PTW_OFF_BASE1:  prdata <= table_base_space1;
          `PTW_OFF_FSTAT:  prdata <= {30'h00000000, fault_code};
          `PTW_OFF_FADDR:  prdata <= fault_address_reg;
          `PTW_OFF_TLBIDX: prdata <= {{(32-TLB_AW){1'b0}}, tlb_index};
          `PTW_OFF_TLBLO:  prdata <= {tlb_rdata[23:4], 8'h00,
                                      tlb_rdata[3:0]};
          `PTW_OFF_TLBHI:  prdata <= {11'h000, tlb_rdata[44:24]};
          `PTW_OFF_STATUS: prdata <= {{(31-TLB_AW){1'b0}}, victim,
                                      ~req_ready};
          default:         prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// >>> tb/ptw_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// page-table memory, answers after a wait
// ------------------------------------------
module ptw_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_we,
  input  wire logic        mem_byte,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [3:0]  wait_cycles,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [0:8191];
  logic [3:0]  cnt = 4'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // sole master here, so a locked pair is never split
  always @(posedge clk_sys)
  begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && cnt < wait_cycles)
      cnt <= cnt + 4'h1;
    else if (mem_req && !mem_ack)
    begin
      cnt     <= 4'h0;
      mem_ack <= 1'b1;
      if (!mem_we)
        mem_rdata <= mem[mem_addr[14:2]];
      else if (mem_byte)
        mem[mem_addr[14:2]][7:0] <= mem_wdata[7:0];
      else
        mem[mem_addr[14:2]] <= mem_wdata;
    end
  end
endmodule

// >>> tb/ptw_walker_sva.sv
`timescale 1ns/1ps
// ------------------------------------------
// port checker
// ------------------------------------------
module ptw_walker_sva (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic        rsp_done,
  input wire logic        noncacheable_out,
  input wire logic        rsp_fault,
  input wire logic        rsp_abort,
  input wire logic        rsp_probe_ok,
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_we,
  input wire logic        mem_byte,
  input wire logic        mem_lock,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_lock_in_walk: assert property (
    mem_lock |-> mem_req) else $error("lock outside a walk");
  a_byte_sets_ref: assert property (
    mem_req && mem_byte |-> mem_we && mem_wdata[7])
    else $error("bad byte update");
  a_rmw_sets_ref: assert property (
    mem_req && mem_we && !mem_byte |-> mem_lock && mem_wdata[7])
    else $error("bad locked update");
  a_hold_request: assert property (
    mem_req && !mem_ack |=> $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_wdata)) else $error("request moved early");
  a_lock_read_first: assert property (
    $rose(mem_lock) |-> !mem_we) else $error("locked pair order");
  a_nc_low_walk: assert property (
    mem_req |-> !noncacheable_out) else $error("noncacheable in walk");
  a_fault_done: assert property (
    rsp_fault |-> rsp_done) else $error("fault without done");
  a_abort_fault: assert property (
    rsp_abort |-> rsp_fault) else $error("abort without fault");
  a_probe_ok: assert property (
    rsp_probe_ok |-> rsp_done && !rsp_fault) else $error("probe flag");
  a_done_pulse: assert property (
    rsp_done |=> !rsp_done) else $error("done too long");
  a_err_access: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "ptw_defines.vh"
// ------------------------------------------
// walker bench
// ------------------------------------------
module tb_top;
  logic        clk_sys = 1'b0, srst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, req_vaddr = 32'h0, prdata, rsp_paddr;
  logic        pready, pslverr, req_ready, req_valid = 1'b0;
  logic        req_user_mode = 1'b0, req_write = 1'b0, req_rmw = 1'b0;
  logic        req_user_to_supervisor_move = 1'b0, req_probe = 1'b0;
  logic        req_supervisor_to_user_move = 1'b0;
  logic        req_speculative = 1'b0;
  logic        rsp_done, noncacheable_out, rsp_fault, rsp_abort;
  logic        rsp_probe_ok, mem_req, mem_we, mem_byte, mem_lock, mem_ack;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, rd, pa, flags;
  logic [3:0]  wait_cycles = 4'h0;
  int          bad_count = 0, samples_checked = 0, mem_cycles = 0;
  localparam logic [31:0] FL1 [8] = '{32'h3081, 32'h3006, 32'h3087,
                                      32'h3087, 32'h3081, 32'h3087,
                                      32'h3006, 32'h3081};
  localparam logic [6:0]  FF [8] = '{7'h08, 7'h00, 7'h00, 7'h40, 7'h28,
                                     7'h20, 7'h20, 7'h10};
  localparam logic [31:0] FE [8] = '{32'h6, 32'h6, 32'h6, 32'h4, 32'h4,
                                     32'h1, 32'h6, 32'h6};
  localparam logic [31:0] FC [8] = '{32'h3, 32'h1, 32'h2, 32'h2, 32'h2,
                                     32'h2, 32'h1, 32'h3};
  ptw_walker dut_u (.clk_sys, .srst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_ready, .req_vaddr,
    .req_user_mode, .req_user_to_supervisor_move, .req_write, .req_rmw,
    .req_supervisor_to_user_move, .req_probe, .req_speculative, .rsp_done,
    .rsp_paddr, .noncacheable_out, .rsp_fault, .rsp_abort, .rsp_probe_ok,
    .mem_req, .mem_addr, .mem_we, .mem_byte, .mem_lock, .mem_wdata,
    .mem_ack, .mem_rdata);
  ptw_mem_model mem_u (.clk_sys, .mem_req, .mem_addr, .mem_we, .mem_byte,
    .mem_wdata, .wait_cycles, .mem_ack, .mem_rdata);
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (mem_req)
      mem_cycles <= mem_cycles + 1;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic timeout();
    bad_count++;
    $display("[FAIL] %0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // ------------------------------------------
  // bus tasks
  // ------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      timeout();
    rd = prdata | {31'h0, pslverr};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic xlat(input logic [31:0] va, input logic [6:0] f);
    int n;
    n = 0;
    {req_speculative, req_probe, req_rmw, req_write,
     req_supervisor_to_user_move, req_user_to_supervisor_move,
     req_user_mode} <= f;
    req_vaddr <= va;
    req_valid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (req_ready !== 1'b1 && n < 50);
    if (n >= 50)
      timeout();
    req_valid <= 1'b0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (rsp_done !== 1'b1 && n < 200);
    if (n >= 200)
      timeout();
    pa = rsp_paddr;
    flags = {28'h0, noncacheable_out, rsp_fault, rsp_abort, rsp_probe_ok};
  endtask
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_regs();
    apb(1'b0, `PTW_OFF_CTRL, 32'h0);
    chk(rd, {28'h0, `PTW_CTRL_RST});
    apb(1'b1, `PTW_OFF_BASE0, 32'h12345678);
    apb(1'b0, `PTW_OFF_BASE0, 32'h0);
    chk(rd, 32'h12345000);
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_walk();
    apb(1'b1, `PTW_OFF_CTRL, 32'h1);
    apb(1'b1, `PTW_OFF_BASE0, 32'h1000);
    mem_u.mem[13'h401] = 32'h00003F5F;
    mem_u.mem[13'hC05] = 32'hABCDEE7F;
    xlat(32'h00405123, 7'h00);
    chk(pa, 32'hABCDE123);
    chk(flags, 32'h8);
    chk(mem_u.mem[13'h401], 32'h00003FDF);
    chk(mem_u.mem[13'hC05], 32'hABCDEEFF);
    $display("test walk done");
  endtask
  task automatic t_pass();
    int n0;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `PTW_OFF_CTRL, i == 0 ? 32'h0 : 32'h1);
      n0 = mem_cycles;
      xlat(32'hDEADBEE0 + i, i == 0 ? 7'h0 : 7'h1 << (i - 1));
      chk(pa, 32'hDEADBEE0 + i);
      chk(flags | 32'(mem_cycles - n0), 32'h0);
    end
    $display("test pass-through done");
  endtask
  task automatic t_user();
    logic [5:0] v;
    apb(1'b1, `PTW_OFF_CTRL, 32'h7);
    apb(1'b1, `PTW_OFF_BASE1, 32'h2000);
    apb(1'b0, `PTW_OFF_STATUS, 32'h0);
    v = rd[6:1];
    mem_u.mem[13'h801] = 32'h00004087;
    mem_u.mem[13'h1005] = 32'h00055007;
    wait_cycles <= 4'h3;
    xlat(32'h00405123, 7'h09);
    wait_cycles <= 4'h0;
    chk(pa, 32'h00055123);
    chk(flags, 32'h0);
    chk(mem_u.mem[13'h1005], 32'h00055187);
    apb(1'b1, `PTW_OFF_TLBIDX, {26'h0, v});
    apb(1'b0, `PTW_OFF_TLBHI, 32'h0);
    chk(rd, 32'h00100405);
    apb(1'b0, `PTW_OFF_TLBLO, 32'h0);
    chk(rd, 32'h0005500D);
    $display("test user write done");
  endtask
  task automatic t_faults();
    apb(1'b1, `PTW_OFF_CTRL, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      mem_u.mem[13'h401] = FL1[i];
      mem_u.mem[13'hC05] = i == 5 ? 32'hABCDE003 : 32'hABCDE006;
      xlat(32'h00405000 + i, FF[i]);
      chk(flags, FE[i]);
      apb(1'b0, `PTW_OFF_FSTAT, 32'h0);
      chk(rd, FC[i]);
      apb(1'b0, `PTW_OFF_FADDR, 32'h0);
      chk(rd, 32'h00405000 + ((i < 3 || i > 5) ? i : 2));
    end
    apb(1'b0, `PTW_OFF_STATUS, 32'h0);
    apb(1'b1, `PTW_OFF_TLBIDX, {26'h0, rd[6:1] - 6'h1});
    apb(1'b0, `PTW_OFF_TLBLO, 32'h0);
    chk(rd, 32'hABCDE004);
    $display("test faults done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_walk();
    t_pass();
    t_user();
    t_faults();
    print_verdict();
  end
endmodule
bind ptw_walker ptw_walker_sva chk_u (.clk_sys, .srst, .psel, .penable,
  .pslverr, .rsp_done, .noncacheable_out, .rsp_fault, .rsp_abort,
  .rsp_probe_ok, .mem_req, .mem_addr, .mem_we, .mem_byte, .mem_lock,
  .mem_wdata, .mem_ack);
